//--- rtl/dec_xor_regs.vh
`ifndef DEC_XOR_REGS_VH
`define DEC_XOR_REGS_VH

// apb register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_ACCUM       8'h08
`define OFS_FLAGS       8'h0C
`define OFS_FIRST_IDX   8'h10
`define OFS_SECOND_IDX  8'h14
`define OFS_STACK       8'h18
`define OFS_PROG_CNT    8'h1C

// field positions
`define CTRL_RUN_BIT    0
`define STAT_BUSY_BIT   0
`define STAT_ILL_BIT    1
`define FLAG_MSB_BIT    3
`define FLAG_ZERO_BIT   2
`define FLAG_WRAP_BIT   1
`define FLAG_BORROW_BIT 0

// reset values
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define RST_FLAGS       8'hD0
`define RST_STACK       16'h00FF

// bus constants
`define DUMMY_ADDR      16'hFFFF
`define DIRECT_PAGE     8'h00
`define ONE_BYTE        8'h01
`define ONE_WORD        16'h0001
`define SIGNED_MIN      8'h80

// opcodes
`define OPC_PREFIX      8'h18
`define OPC_DEC_A       8'h4A
`define OPC_DEC_B       8'h5A
`define OPC_DEC_EXT     8'h7A
`define OPC_DEC_IDX     8'h6A
`define OPC_DEC_SP      8'h34
`define OPC_DEC_IDXREG  8'h09
`define OPC_XOR_A_IMM   8'h88
`define OPC_XOR_A_DIR   8'h98
`define OPC_XOR_A_EXT   8'hB8
`define OPC_XOR_A_IDX   8'hA8
`define OPC_XOR_B_IMM   8'hC8
`define OPC_XOR_B_DIR   8'hD8
`define OPC_XOR_B_EXT   8'hF8
`define OPC_XOR_B_IDX   8'hE8

`endif

//--- rtl/step_alu.v
`timescale 1ns/1ns
// 8-bit subtract-one / xor and 16-bit index subtract-one
module step_alu (
  // 8-bit path
  input  wire        op_xor,
  input  wire [7:0]  acc_val,
  input  wire [7:0]  opnd,
  output reg  [7:0]  res,
  output wire        res_msb,
  output wire        res_zero,
  output wire        res_wrap,
  // 16-bit index path
  input  wire [15:0] idx_val,
  output wire [15:0] idx_dec,
  output wire        idx_zero
);

`include "dec_xor_regs.vh"

  always @* begin
    if (op_xor) begin
      res = acc_val ^ opnd;
    end else begin
      res = opnd - `ONE_BYTE;
    end
  end

  assign res_msb  = res[7];
  assign res_zero = (res == 8'h00);
  // wrap only when the operand was the most negative value
  assign res_wrap = ~op_xor & (opnd == `SIGNED_MIN);
  assign idx_dec  = idx_val - `ONE_WORD;
  assign idx_zero = (idx_dec == 16'h0000);

endmodule

//--- rtl/decrement_xor_execution.v
// Functional notes
// - subtract one, write back same location
// - 8-bit decrement updates N Z V, keeps C
// - msb flag from bit 7, zero flag
// - wrap flag set only for operand 80
// - 4A/5A accumulator forms, two cycles
// - memory forms read, dummy FFFF, write
// - 34 decrements stack, three cycles, no flags
// - 09 decrements first index, dummy FFFF
// - index decrement changes only zero flag
// - 18 09 decrements second index, four cycles
// - xor into accumulator, V cleared, C kept
// - xor cycle counts, indexed dummy FFFF
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module decrement_xor_execution (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // processor memory bus, same clock
  output reg  [15:0] mem_addr,
  output reg         mem_rw,
  output reg  [7:0]  mem_wdata,
  output reg         mem_cycle,
  input  wire [7:0]  mem_rdata
);

`include "dec_xor_regs.vh"

  localparam S_IDLE   = 10'b00_0000_0001;
  localparam S_FETCH  = 10'b00_0000_0010;
  localparam S_OP2    = 10'b00_0000_0100;
  localparam S_B1     = 10'b00_0000_1000;
  localparam S_B2     = 10'b00_0001_0000;
  localparam S_DUMMY  = 10'b00_0010_0000;
  localparam S_OPER   = 10'b00_0100_0000;
  localparam S_DUMMY2 = 10'b00_1000_0000;
  localparam S_WRITE  = 10'b01_0000_0000;
  localparam S_SPRD   = 10'b10_0000_0000;

  localparam K_DEC_ACC = 3'd1;
  localparam K_DEC_MEM = 3'd2;
  localparam K_DES     = 3'd3;
  localparam K_DIX     = 3'd4;
  localparam K_XOR     = 3'd5;

  localparam M_INH = 3'd0;
  localparam M_IMM = 3'd1;
  localparam M_DIR = 3'd2;
  localparam M_EXT = 3'd3;
  localparam M_IDX = 3'd4;

  reg  [9:0]  state_q;
  reg  [2:0]  kind_q;
  reg  [2:0]  mode_q;
  reg         accb_q;
  reg         prefix_q;
  reg  [7:0]  hi_q;
  reg  [7:0]  opnd_q;
  reg  [15:0] ea_q;
  reg  [7:0]  acc_a_q;
  reg  [7:0]  acc_b_q;
  reg  [7:0]  flag_register_q;
  reg  [15:0] first_index_register_q;
  reg  [15:0] second_index_register_q;
  reg  [15:0] stack_q;
  reg  [15:0] pc_q;
  reg         run_q;
  reg         illegal_q;
  reg  [31:0] rd_d;
  reg         err_d;

  wire [15:0] pc_inc = pc_q + `ONE_WORD;
  wire        apb_wr = psel & penable & pready & pwrite;
  wire        idle   = (state_q == S_IDLE);
  wire        go     = run_q & ~illegal_q;
  wire [7:0]  dec_fields = decode(mem_rdata, state_q == S_OP2);
  wire [7:0]  sel_acc = accb_q ? acc_b_q : acc_a_q;
  wire [15:0] sel_idx = prefix_q ? second_index_register_q
                                 : first_index_register_q;
  wire [7:0]  alu_opnd = (kind_q == K_DEC_ACC) ? sel_acc :
                         (kind_q == K_DEC_MEM) ? opnd_q : mem_rdata;
  wire [7:0]  alu_res;
  wire        alu_msb;
  wire        alu_zero;
  wire        alu_wrap;
  wire [15:0] idx_dec;
  wire        idx_zero;

  // {valid, kind, mode, accumulator b}
  function [7:0] decode;
    input [7:0] op;
    input       pre;
    begin
      decode = 8'h00;
      if (!pre) begin
        case (op)
          `OPC_DEC_A:      decode = {1'b1, K_DEC_ACC, M_INH, 1'b0};
          `OPC_DEC_B:      decode = {1'b1, K_DEC_ACC, M_INH, 1'b1};
          `OPC_DEC_EXT:    decode = {1'b1, K_DEC_MEM, M_EXT, 1'b0};
          `OPC_DEC_IDX:    decode = {1'b1, K_DEC_MEM, M_IDX, 1'b0};
          `OPC_DEC_SP:     decode = {1'b1, K_DES, M_INH, 1'b0};
          `OPC_DEC_IDXREG: decode = {1'b1, K_DIX, M_INH, 1'b0};
          `OPC_XOR_A_IMM:  decode = {1'b1, K_XOR, M_IMM, 1'b0};
          `OPC_XOR_A_DIR:  decode = {1'b1, K_XOR, M_DIR, 1'b0};
          `OPC_XOR_A_EXT:  decode = {1'b1, K_XOR, M_EXT, 1'b0};
          `OPC_XOR_A_IDX:  decode = {1'b1, K_XOR, M_IDX, 1'b0};
          `OPC_XOR_B_IMM:  decode = {1'b1, K_XOR, M_IMM, 1'b1};
          `OPC_XOR_B_DIR:  decode = {1'b1, K_XOR, M_DIR, 1'b1};
          `OPC_XOR_B_EXT:  decode = {1'b1, K_XOR, M_EXT, 1'b1};
          `OPC_XOR_B_IDX:  decode = {1'b1, K_XOR, M_IDX, 1'b1};
          default:         decode = 8'h00;
        endcase
      end else begin
        case (op)
          `OPC_DEC_IDX:    decode = {1'b1, K_DEC_MEM, M_IDX, 1'b0};
          `OPC_DEC_IDXREG: decode = {1'b1, K_DIX, M_INH, 1'b0};
          `OPC_XOR_A_IDX:  decode = {1'b1, K_XOR, M_IDX, 1'b0};
          `OPC_XOR_B_IDX:  decode = {1'b1, K_XOR, M_IDX, 1'b1};
          default:         decode = 8'h00;
        endcase
      end
    end
  endfunction

  step_alu u_alu (
    .op_xor   (kind_q == K_XOR),
    .acc_val  (sel_acc),
    .opnd     (alu_opnd),
    .res      (alu_res),
    .res_msb  (alu_msb),
    .res_zero (alu_zero),
    .res_wrap (alu_wrap),
    .idx_val  (sel_idx),
    .idx_dec  (idx_dec),
    .idx_zero (idx_zero)
  );

  // msb, zero and wrap from the alu; borrow is never touched here
  task set_flags8;
    begin
      flag_register_q[`FLAG_MSB_BIT]  <= alu_msb;
      flag_register_q[`FLAG_ZERO_BIT] <= alu_zero;
      flag_register_q[`FLAG_WRAP_BIT] <= alu_wrap;
    end
  endtask

  task write_acc;
    begin
      if (accb_q) begin
        acc_b_q <= alu_res;
      end else begin
        acc_a_q <= alu_res;
      end
    end
  endtask

  // end of instruction: fetch the next opcode or stop
  task finish;
    input [15:0] next_pc;
    begin
      pc_q      <= next_pc;
      mem_rw    <= 1'b1;
      state_q   <= go ? S_FETCH : S_IDLE;
      mem_addr  <= go ? next_pc : `DUMMY_ADDR;
      mem_cycle <= go;
    end
  endtask

  task bus_read;
    input [9:0]  nxt;
    input [15:0] adr;
    begin
      state_q   <= nxt;
      mem_addr  <= adr;
      mem_rw    <= 1'b1;
      mem_cycle <= 1'b1;
    end
  endtask

  // instruction sequencer and programmer-visible registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q                 <= S_IDLE;
      kind_q                  <= 3'd0;
      mode_q                  <= M_INH;
      accb_q                  <= 1'b0;
      prefix_q                <= 1'b0;
      hi_q                    <= `RST_BYTE;
      opnd_q                  <= `RST_BYTE;
      ea_q                    <= `RST_WORD;
      acc_a_q                 <= `RST_BYTE;
      acc_b_q                 <= `RST_BYTE;
      flag_register_q         <= `RST_FLAGS;
      first_index_register_q  <= `RST_WORD;
      second_index_register_q <= `RST_WORD;
      stack_q                 <= `RST_STACK;
      pc_q                    <= `RST_WORD;
      illegal_q               <= 1'b0;
      mem_addr                <= `DUMMY_ADDR;
      mem_rw                  <= 1'b1;
      mem_wdata               <= `RST_BYTE;
      mem_cycle               <= 1'b0;
    end else begin
      // a new fault beats a clear in the same cycle
      if (apb_wr && paddr == `OFS_STATUS && pwdata[`STAT_ILL_BIT]) begin
        illegal_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (apb_wr) begin
            case (paddr)
              `OFS_ACCUM: begin
                acc_a_q <= pwdata[7:0];
                acc_b_q <= pwdata[15:8];
              end
              `OFS_FLAGS:      flag_register_q <= pwdata[7:0];
              `OFS_FIRST_IDX:  first_index_register_q <= pwdata[15:0];
              `OFS_SECOND_IDX: second_index_register_q <= pwdata[15:0];
              `OFS_STACK:      stack_q <= pwdata[15:0];
              `OFS_PROG_CNT:   pc_q <= pwdata[15:0];
              default: begin
              end
            endcase
          end
          if (go) begin
            bus_read(S_FETCH, pc_q);
          end
        end
        S_FETCH: begin
          pc_q <= pc_inc;
          if (mem_rdata == `OPC_PREFIX) begin
            prefix_q <= 1'b1;
            bus_read(S_OP2, pc_inc);
          end else begin
            prefix_q <= 1'b0;
            if (dec_fields[7]) begin
              {kind_q, mode_q, accb_q} <= dec_fields[6:0];
              bus_read(S_B1, pc_inc);
            end else begin
              illegal_q <= 1'b1;
              finish(pc_inc);
              state_q   <= S_IDLE;
              mem_addr  <= `DUMMY_ADDR;
              mem_cycle <= 1'b0;
            end
          end
        end
        S_OP2: begin
          pc_q <= pc_inc;
          if (dec_fields[7]) begin
            {kind_q, mode_q, accb_q} <= dec_fields[6:0];
            bus_read(S_B1, pc_inc);
          end else begin
            illegal_q <= 1'b1;
            pc_q      <= pc_inc;
            state_q   <= S_IDLE;
            mem_addr  <= `DUMMY_ADDR;
            mem_cycle <= 1'b0;
          end
        end
        S_B1: begin
          case (mode_q)
            M_INH: begin
              // next-address read only, program counter stays
              if (kind_q == K_DEC_ACC) begin
                write_acc;
                set_flags8;
                finish(pc_q);
              end else if (kind_q == K_DES) begin
                bus_read(S_SPRD, stack_q);
              end else begin
                bus_read(S_DUMMY, `DUMMY_ADDR);
              end
            end
            M_IMM: begin
              write_acc;
              set_flags8;
              finish(pc_inc);
            end
            M_DIR: begin
              pc_q <= pc_inc;
              ea_q <= {`DIRECT_PAGE, mem_rdata};
              bus_read(S_OPER, {`DIRECT_PAGE, mem_rdata});
            end
            M_EXT: begin
              pc_q <= pc_inc;
              hi_q <= mem_rdata;
              bus_read(S_B2, pc_inc);
            end
            default: begin
              pc_q <= pc_inc;
              ea_q <= sel_idx + {8'h00, mem_rdata};
              bus_read(S_DUMMY, `DUMMY_ADDR);
            end
          endcase
        end
        S_B2: begin
          pc_q <= pc_inc;
          ea_q <= {hi_q, mem_rdata};
          bus_read(S_OPER, {hi_q, mem_rdata});
        end
        S_DUMMY: begin
          if (kind_q == K_DIX) begin
            if (prefix_q) begin
              second_index_register_q <= idx_dec;
            end else begin
              first_index_register_q <= idx_dec;
            end
            flag_register_q[`FLAG_ZERO_BIT] <= idx_zero;
            finish(pc_q);
          end else begin
            bus_read(S_OPER, ea_q);
          end
        end
        S_OPER: begin
          if (kind_q == K_XOR) begin
            write_acc;
            set_flags8;
            finish(pc_q);
          end else begin
            opnd_q <= mem_rdata;
            bus_read(S_DUMMY2, `DUMMY_ADDR);
          end
        end
        S_DUMMY2: begin
          set_flags8;
          mem_wdata <= alu_res;
          state_q   <= S_WRITE;
          mem_addr  <= ea_q;
          mem_rw    <= 1'b0;
          mem_cycle <= 1'b1;
        end
        S_WRITE: begin
          finish(pc_q);
        end
        S_SPRD: begin
          stack_q <= stack_q - `ONE_WORD;
          finish(pc_q);
        end
        default: begin
          state_q   <= S_IDLE;
          mem_addr  <= `DUMMY_ADDR;
          mem_rw    <= 1'b1;
          mem_cycle <= 1'b0;
        end
      endcase
    end
  end

  // apb read data and error, prepared in the setup cycle
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `OFS_CTRL:       rd_d[`CTRL_RUN_BIT] = run_q;
      `OFS_STATUS: begin
        rd_d[`STAT_BUSY_BIT] = ~idle;
        rd_d[`STAT_ILL_BIT]  = illegal_q;
      end
      `OFS_ACCUM:      rd_d[15:0] = {acc_b_q, acc_a_q};
      `OFS_FLAGS:      rd_d[7:0]  = flag_register_q;
      `OFS_FIRST_IDX:  rd_d[15:0] = first_index_register_q;
      `OFS_SECOND_IDX: rd_d[15:0] = second_index_register_q;
      `OFS_STACK:      rd_d[15:0] = stack_q;
      `OFS_PROG_CNT:   rd_d[15:0] = pc_q;
      default:         err_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      run_q   <= 1'b0;
    end else begin
      // one wait-free access phase after each setup cycle
      pready <= psel & ~penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr <= err_d;
      end else begin
        pslverr <= 1'b0;
      end
      if (apb_wr && paddr == `OFS_CTRL) begin
        run_q <= pwdata[`CTRL_RUN_BIT];
      end
    end
  end

endmodule

//--- verification/dec_xor_chk.sv
`timescale 1ns/1ns
module dec_xor_chk (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // processor memory bus
  input wire [15:0] mem_addr,
  input wire        mem_rw,
  input wire [7:0]  mem_wdata,
  input wire        mem_cycle,
  input wire [7:0]  mem_rdata
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // read-modify-write steps
  sequence opnd_rd;
    mem_cycle && mem_rw && mem_addr != 16'hFFFF;
  endsequence
  sequence dummy_rd;
    mem_cycle && mem_rw && mem_addr == 16'hFFFF;
  endsequence
  sequence wr_back;
    mem_cycle && !mem_rw;
  endsequence

  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("apb answer missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_read: assert property (pslverr |-> pready && (pwrite || prdata == 0))
    else $error("error response malformed");
  a_bus_idle: assert property (!mem_cycle |-> mem_addr == 16'hFFFF && mem_rw)
    else $error("idle bus not parked");
  a_rmw_order: assert property (wr_back |-> $past(mem_cycle)
    && $past(mem_rw) && $past(mem_addr) == 16'hFFFF)
    else $error("write not after dummy read");
  a_rmw_addr: assert property (opnd_rd ##1 dummy_rd ##1 wr_back
    |-> mem_addr == $past(mem_addr, 2))
    else $error("write back to other address");
  a_rmw_data: assert property (opnd_rd ##1 dummy_rd ##1 wr_back
    |-> mem_wdata == $past(mem_rdata, 2) - 8'h01)
    else $error("written byte is not operand minus one");
  a_dummy_read: assert property (
    mem_cycle && mem_addr == 16'hFFFF |-> mem_rw)
    else $error("dummy cycle writes");
  a_write_single: assert property (
    wr_back |=> !mem_cycle || mem_rw)
    else $error("two write cycles in a row");
endmodule

bind decrement_xor_execution dec_xor_chk chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rw(mem_rw),
  .mem_wdata(mem_wdata), .mem_cycle(mem_cycle), .mem_rdata(mem_rdata)
);

//--- verification/mem_model.sv
`timescale 1ns/1ns
module mem_model (
  // clock
  input  wire        pclk,
  // processor bus
  input  wire [15:0] mem_addr,
  input  wire        mem_rw,
  input  wire [7:0]  mem_wdata,
  input  wire        mem_cycle,
  output wire [7:0]  mem_rdata
);
  reg     [7:0] m [0:65535];
  reg     [7:0] last_q;
  integer       i;

  // byte 00 is no defined opcode, so it ends every program
  initial begin
    for (i = 0; i < 65536; i = i + 1)
      m[i] = 8'h00;
    last_q = 8'h00;
  end
  // zero wait; a bus not read shows the inverse of the last byte
  assign mem_rdata = (mem_cycle && mem_rw) ? m[mem_addr] : ~last_q;
  always @(posedge pclk) begin
    if (mem_cycle && !mem_rw)
      m[mem_addr] <= mem_wdata;
    if (mem_cycle && mem_rw)
      last_q <= m[mem_addr];
  end
endmodule

//--- verification/decrement_xor_execution_test.sv
`timescale 1ns/1ns
module decrement_xor_execution_test;
  reg         pclk;
  reg         presetn;
  reg  [7:0]  paddr;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [15:0] mem_addr;
  wire        mem_rw;
  wire [7:0]  mem_wdata;
  wire        mem_cycle;
  wire [7:0]  mem_rdata;
  integer     bad_count;
  integer     compares;
  integer     ncyc;
  integer     k;
  reg  [31:0] q;
  reg         e;
  reg  [31:0] prog;
  reg  [7:0]  v;
  reg  [47:0] xt [0:4];

  decrement_xor_execution dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
    .mem_rw(mem_rw), .mem_wdata(mem_wdata), .mem_cycle(mem_cycle),
    .mem_rdata(mem_rdata)
  );
  mem_model mem (
    .pclk(pclk), .mem_addr(mem_addr), .mem_rw(mem_rw),
    .mem_wdata(mem_wdata), .mem_cycle(mem_cycle), .mem_rdata(mem_rdata)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (mem_cycle === 1'b1)
      ncyc <= ncyc + 1;

  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input string n, input [31:0] x, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== x) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        i = i + 1;
        if (i > 20) begin
          chk("pready", 32'h0000_0001, {31'h0, pready});
          tally_and_finish;
        end
        @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rc(input string n, input [7:0] a, input [31:0] x);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(n, x, q);
    end
  endtask

  // load a program at 0100, set the core up, run it to the stop byte
  task tc(input [31:0] p, input [15:0] acc, input [7:0] fl,
          input [15:0] ix, input integer len, input integer cyc,
          input [15:0] eacc, input [7:0] efl, input [15:0] ex,
          input [15:0] ey, input [15:0] esp);
    integer i;
    integer n0;
    begin
      for (i = 0; i < 4; i = i + 1)
        mem.m[16'h0100 + i] = p[31 - 8 * i -: 8];
      apb(1'b1, 8'h08, {16'h0000, acc});
      apb(1'b1, 8'h0C, {24'h00_0000, fl});
      apb(1'b1, 8'h10, {16'h0000, ix});
      apb(1'b1, 8'h14, {16'h0000, ix});
      apb(1'b1, 8'h18, 32'h0000_0200);
      apb(1'b1, 8'h1C, 32'h0000_0100);
      n0 = ncyc;
      apb(1'b1, 8'h00, 32'h0000_0001);
      q = 32'h0000_0000;
      i = 0;
      while (q[1:0] !== 2'b10) begin
        i = i + 1;
        if (i > 30) begin
          chk("status", 32'h0000_0002, q);
          tally_and_finish;
        end
        apb(1'b0, 8'h04, 32'h0000_0000);
      end
      apb(1'b1, 8'h00, 32'h0000_0000);
      apb(1'b1, 8'h04, 32'h0000_0002);
      // the stop byte fetch is one more bus cycle
      chk("cycles", cyc + 1, ncyc - n0);
      rc("accum", 8'h08, {16'h0000, eacc});
      rc("flags", 8'h0C, {24'h00_0000, efl});
      rc("first idx", 8'h10, {16'h0000, ex});
      rc("second idx", 8'h14, {16'h0000, ey});
      rc("stack", 8'h18, {16'h0000, esp});
      rc("prog cnt", 8'h1C, 32'h0000_0101 + len);
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bad_count = 0;
    compares = 0;
    ncyc = 0;
    xt[0] = {32'h885A_0000, 8'h5A, 4'h2, 4'h2};
    xt[1] = {32'h9810_0000, 8'hFF, 4'h2, 4'h3};
    xt[2] = {32'hB823_4500, 8'h7F, 4'h3, 4'h4};
    xt[3] = {32'hA820_0000, 8'hFF, 4'h2, 4'h4};
    xt[4] = {32'h18A8_2000, 8'hFF, 4'h3, 4'h5};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl", 8'h00, 32'h0000_0000);
    rc("accum", 8'h08, 32'h0000_0000);
    rc("flags", 8'h0C, 32'h0000_00D0);
    rc("stack", 8'h18, 32'h0000_00FF);
    rc("prog cnt", 8'h1C, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0001);
    rc("status", 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    chk("write err", 32'h0000_0001, {31'h0, e});
    rc("unmapped", 8'h20, 32'h0000_0000);
    chk("read err", 32'h0000_0001, {31'h0, e});
    $display("registers done");
    mem.m[16'h2345] = 8'h80;
    mem.m[16'h0010] = 8'h01;
    tc(32'h4A00_0000, 16'h0080, 8'hD1, 16'hFFF0, 1, 2, 16'h007F, 8'hD3,
       16'hFFF0, 16'hFFF0, 16'h0200);
    tc(32'h5A00_0000, 16'h0100, 8'hD0, 16'hFFF0, 1, 2, 16'h0000, 8'hD4,
       16'hFFF0, 16'hFFF0, 16'h0200);
    tc(32'h5A00_0000, 16'h0000, 8'hD1, 16'hFFF0, 1, 2, 16'hFF00, 8'hD9,
       16'hFFF0, 16'hFFF0, 16'h0200);
    tc(32'h3400_0000, 16'h0000, 8'hD7, 16'hFFF0, 1, 3, 16'h0000, 8'hD7,
       16'hFFF0, 16'hFFF0, 16'h01FF);
    tc(32'h0900_0000, 16'h0000, 8'hD8, 16'h0001, 1, 3, 16'h0000, 8'hDC,
       16'h0000, 16'h0001, 16'h0200);
    tc(32'h1809_0000, 16'h0000, 8'hDF, 16'h0002, 2, 4, 16'h0000, 8'hDB,
       16'h0002, 16'h0001, 16'h0200);
    $display("register forms done");
    tc(32'h7A23_4500, 16'h0000, 8'hD1, 16'hFFF0, 3, 6, 16'h0000, 8'hD3,
       16'hFFF0, 16'hFFF0, 16'h0200);
    chk("mem 2345", 32'h0000_007F, {24'h00_0000, mem.m[16'h2345]});
    tc(32'h6A20_0000, 16'h0000, 8'hD0, 16'hFFF0, 2, 6, 16'h0000, 8'hD4,
       16'hFFF0, 16'hFFF0, 16'h0200);
    chk("mem 0010", 32'h0000_0000, {24'h00_0000, mem.m[16'h0010]});
    tc(32'h186A_2000, 16'h0000, 8'hD1, 16'hFFF0, 3, 7, 16'h0000, 8'hD9,
       16'hFFF0, 16'hFFF0, 16'h0200);
    chk("mem 0010", 32'h0000_00FF, {24'h00_0000, mem.m[16'h0010]});
    $display("memory forms done");
    for (k = 0; k < 10; k = k + 1) begin
      prog = xt[k % 5][47:16];
      v = xt[k % 5][15:8] ^ 8'h5A;
      if (k >= 5 && k != 9)
        prog[31:24] = prog[31:24] + 8'h40;
      if (k == 9)
        prog[23:16] = prog[23:16] + 8'h40;
      tc(prog, 16'h5A5A, 8'hD3, 16'hFFF0, xt[k % 5][7:4], xt[k % 5][3:0],
         (k < 5) ? {8'h5A, v} : {v, 8'h5A}, {4'hD, v[7], v == 8'h00, 2'b01},
         16'hFFF0, 16'hFFF0, 16'h0200);
    end
    $display("xor forms done");
    // a prefixed form followed at once by an unprefixed indexed form
    tc(32'h1809_6A20, 16'h0000, 8'hD0, 16'hFFF0, 4, 10, 16'h0000, 8'hD8,
       16'hFFF0, 16'hFFEF, 16'h0200);
    chk("mem 0010", 32'h0000_00FE, {24'h00_0000, mem.m[16'h0010]});
    $display("prefix chain done");
    tally_and_finish;
  end
endmodule
